// file: common/pci_term_pkg.sv
`default_nettype none
package pci_term_pkg;

  // Clocks a target is given to claim after FRAME# is driven
  localparam int          DEVSEL_WAIT_CLK = 5;

  // Synchroniser bit positions and idle value of the sampled pins
  localparam int          SY_DEVSEL = 4;
  localparam int          SY_STOP   = 3;
  localparam int          SY_GNT    = 2;
  localparam int          SY_FRAME  = 1;
  localparam int          SY_IRDY   = 0;
  localparam logic [4:0]  SYNC_RST  = 5'h1f;

  // Status flag positions, shared by both status registers
  localparam int          ST_MA     = 0;
  localparam int          ST_TAR    = 1;
  localparam int          ST_TAS    = 2;
  localparam int          ST_SES    = 3;
  localparam logic [3:0]  STATUS_RST = 4'h0;

  localparam logic [63:0] ALL_ONES  = 64'hffff_ffff_ffff_ffff;
  localparam logic [63:0] DATA_RST  = 64'h0000_0000_0000_0000;

  typedef enum logic [2:0] {
    T_NONE       = 3'h0,
    T_NORMAL     = 3'h1,
    T_RETRY      = 3'h2,
    T_DISC_WITH  = 3'h3,
    T_DISC_AFTER = 3'h4,
    T_TABORT     = 3'h5,
    T_MABORT     = 3'h6
  } tkind_t;

  typedef enum logic [1:0] {
    R_OK     = 2'h0,
    R_MABORT = 2'h1,
    R_TABORT = 2'h2
  } mres_t;

  typedef enum logic [1:0] {
    MS_IDLE = 2'b00,
    MS_ADDR = 2'b01,
    MS_DATA = 2'b11,
    MS_HOLD = 2'b10
  } mst_state_t;

  typedef enum logic {
    TS_IDLE = 1'b0,
    TS_STOP = 1'b1
  } tgt_state_t;

  typedef enum logic {
    ST_IDLE = 1'b0,
    ST_FWD  = 1'b1
  } top_state_t;

  // Sticky flag update; a set in the clearing cycle wins
  function automatic logic [3:0] status_upd(input logic [3:0] q,
                                            input logic [3:0] set,
                                            input logic [3:0] clr);
    status_upd = (q & ~clr) | set;
  endfunction

endpackage
`default_nettype wire

// file: common/term_if.sv
`timescale 1ns/100ps
`default_nettype none
interface term_if;
  import pci_term_pkg::*;
  logic   mst_start;
  logic   mst_mwi;
  logic   mst_special;
  logic   tb_devsel_n;
  logic   tb_stop_n;
  logic   init_done;
  logic   gnt_lost;
  logic   lat_expired;
  logic   cl_done;
  logic   mst_done;
  mres_t  mst_res;
  logic   mst_frame_drop;
  logic   mst_hold;
  tkind_t tgt_kind;
  logic   init_frame_n;
  logic   tgt_stop_n;
  logic   tgt_devsel_n;
  logic   tgt_trdy_n;
  logic   tgt_oe;

  modport ctl (output mst_start, mst_mwi, mst_special, tb_devsel_n,
               tb_stop_n, init_done, gnt_lost, lat_expired, cl_done,
               tgt_kind, init_frame_n,
               input  mst_done, mst_res, mst_frame_drop, mst_hold,
               tgt_stop_n, tgt_devsel_n, tgt_trdy_n, tgt_oe);
  modport mst (input  mst_start, mst_mwi, mst_special, tb_devsel_n,
               tb_stop_n, init_done, gnt_lost, lat_expired, cl_done,
               output mst_done, mst_res, mst_frame_drop, mst_hold);
  modport tgt (input  tgt_kind, init_frame_n,
               output tgt_stop_n, tgt_devsel_n, tgt_trdy_n, tgt_oe);
endinterface
`default_nettype wire

// file: hw/master_term.sv
`timescale 1ns/100ps
`default_nettype none
module master_term (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic rstn,
  // Link to the termination controller
  term_if.mst       ifc
);
  import pci_term_pkg::*;

  localparam logic [2:0] DEV_MAX = 3'(DEVSEL_WAIT_CLK);

  typedef struct packed {
    mst_state_t st;
    logic [2:0] cnt;
    logic       mwi;
    logic       special;
    logic       done;
    mres_t      res;
    logic       drop;
  } mst_regs_t;

  mst_regs_t q, d;

  always_comb
  begin
    d = q;
    d.done = 1'b0;
    d.drop = 1'b0;
    case (q.st)
      MS_IDLE:
        if (ifc.mst_start)
        begin
          d.st = MS_ADDR;
          d.cnt = 3'h0;
          d.mwi = ifc.mst_mwi;
          d.special = ifc.mst_special;
        end
      MS_ADDR:
        if (!ifc.tb_devsel_n)
          d.st = MS_DATA;
        else if (q.cnt == DEV_MAX)
        begin
          // Nobody claims a special cycle; that is its normal end
          d.st = MS_IDLE;
          d.done = 1'b1;
          d.res = q.special ? R_OK : R_MABORT;
        end
        else
          d.cnt = q.cnt + 3'h1;
      MS_DATA, MS_HOLD:
        if (!ifc.tb_stop_n)
        begin
          d.st = MS_IDLE;
          d.done = 1'b1;
          d.res = ifc.tb_devsel_n ? R_TABORT : R_OK;
        end
        else if (ifc.init_done || (q.st == MS_HOLD && ifc.cl_done))
        begin
          d.st = MS_IDLE;
          d.done = 1'b1;
          d.drop = 1'b1;
          d.res = R_OK;
        end
        else if (q.st == MS_DATA && ifc.gnt_lost && ifc.lat_expired)
        begin
          if (q.mwi)
            d.st = MS_HOLD;
          else
          begin
            d.st = MS_IDLE;
            d.done = 1'b1;
            d.drop = 1'b1;
            d.res = R_OK;
          end
        end
      default: d.st = MS_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
      q <= '{st: MS_IDLE, cnt: 3'h0, mwi: 1'b0, special: 1'b0,
             done: 1'b0, res: R_OK, drop: 1'b0};
    else
      q <= d;
  end

  assign ifc.mst_done       = q.done;
  assign ifc.mst_res        = q.res;
  assign ifc.mst_frame_drop = q.drop;
  assign ifc.mst_hold       = (q.st == MS_HOLD);

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  devsel_timeout_a: assert property (
    q.st == MS_ADDR && q.cnt == DEV_MAX && ifc.tb_devsel_n && !q.special
    |=> ifc.mst_done && ifc.mst_res == R_MABORT)
    else $error("missing DEVSEL did not master-abort");
  special_no_ma_a: assert property (
    ifc.mst_done |-> !(q.special && ifc.mst_res == R_MABORT))
    else $error("special cycle master-aborted");
  mwi_hold_a: assert property (
    q.st == MS_HOLD && !ifc.cl_done && ifc.tb_stop_n && !ifc.init_done
    |=> ifc.mst_hold && !ifc.mst_frame_drop)
    else $error("bus released before cacheline moved");
  completion_a: assert property (
    q.st == MS_DATA && ifc.tb_stop_n && ifc.init_done
    |=> ifc.mst_frame_drop && ifc.mst_done)
    else $error("no completion after initiator finished");
endmodule
`default_nettype wire

// file: hw/target_term.sv
`timescale 1ns/100ps
`default_nettype none
module target_term (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic rstn,
  // Link to the termination controller
  term_if.tgt       ifc
);
  import pci_term_pkg::*;

  typedef struct packed {
    tgt_state_t st;
    logic       stop_n;
    logic       devsel_n;
    logic       trdy_n;
    logic       oe;
  } tgt_regs_t;

  tgt_regs_t q, d;

  always_comb
  begin
    d = q;
    case (q.st)
      TS_IDLE:
      begin
        d = '{st: TS_IDLE, stop_n: 1'b1, devsel_n: 1'b1, trdy_n: 1'b1,
              oe: 1'b0};
        case (ifc.tgt_kind)
          T_NORMAL:
            d = '{st: TS_IDLE, stop_n: 1'b1, devsel_n: 1'b0, trdy_n: 1'b0,
                  oe: 1'b1};
          T_RETRY, T_DISC_AFTER:
            d = '{st: TS_STOP, stop_n: 1'b0, devsel_n: 1'b0, trdy_n: 1'b1,
                  oe: 1'b1};
          T_DISC_WITH:
            d = '{st: TS_STOP, stop_n: 1'b0, devsel_n: 1'b0, trdy_n: 1'b0,
                  oe: 1'b1};
          T_TABORT:
            d = '{st: TS_STOP, stop_n: 1'b0, devsel_n: 1'b1, trdy_n: 1'b1,
                  oe: 1'b1};
          default: ;
        endcase
      end
      TS_STOP:
      begin
        // Only one data word goes with a disconnect
        d.trdy_n = 1'b1;
        if (ifc.init_frame_n)
          d = '{st: TS_IDLE, stop_n: 1'b1, devsel_n: 1'b1, trdy_n: 1'b1,
                oe: 1'b0};
      end
      default: d.st = TS_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
      q <= '{st: TS_IDLE, stop_n: 1'b1, devsel_n: 1'b1, trdy_n: 1'b1,
             oe: 1'b0};
    else
      q <= d;
  end

  assign ifc.tgt_stop_n   = q.stop_n;
  assign ifc.tgt_devsel_n = q.devsel_n;
  assign ifc.tgt_trdy_n   = q.trdy_n;
  assign ifc.tgt_oe       = q.oe;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  stop_hold_a: assert property (
    !ifc.tgt_stop_n && !ifc.init_frame_n |=> !ifc.tgt_stop_n)
    else $error("STOP released while FRAME still asserted");
  retry_code_a: assert property (
    q.st == TS_IDLE && ifc.tgt_kind == T_RETRY
    |=> !ifc.tgt_stop_n && !ifc.tgt_devsel_n && ifc.tgt_trdy_n)
    else $error("retry signalled with wrong encoding");
  tabort_code_a: assert property (
    q.st == TS_IDLE && ifc.tgt_kind == T_TABORT
    |=> !ifc.tgt_stop_n && ifc.tgt_devsel_n)
    else $error("target-abort with DEVSEL asserted");
  disc_code_a: assert property (
    q.st == TS_IDLE && ifc.tgt_kind == T_DISC_WITH
    |=> !ifc.tgt_stop_n && !ifc.tgt_trdy_n ##1 ifc.tgt_trdy_n)
    else $error("disconnect with data moved more than one word");
endmodule
`default_nettype wire

// file: hw/pci_termination.sv
`timescale 1ns/100ps
`default_nettype none
module pci_termination (
  // Clock and reset
  input  wire logic                clk_sys,
  input  wire logic                rstn,
  // Configuration
  input  wire logic                abort_reporting_select,
  input  wire logic                serr_enable,
  input  wire logic                init_bus64,
  // Status, write one to clear
  input  wire logic [3:0]          primary_status_clear,
  input  wire logic [3:0]          secondary_status_clear,
  output logic      [3:0]          primary_status_reg,
  output logic      [3:0]          secondary_status_reg,
  // Forwarding request toward the target bus
  input  wire logic                mst_req,
  input  wire logic                mst_side,
  input  wire logic                mst_read,
  input  wire logic                mst_posted,
  input  wire logic                mst_mwi,
  input  wire logic                mst_special,
  input  wire logic                mst_locked,
  output logic                     mst_busy,
  input  wire logic                lat_expired,
  input  wire logic                cacheline_done,
  // Target bus pins
  input  wire logic                tb_devsel_n,
  input  wire logic                tb_stop_n,
  input  wire logic                tb_gnt_n,
  output logic                     tb_frame_drop,
  output logic                     tb_hold_bus,
  // Initiating bus pins
  input  wire logic                init_frame_n,
  input  wire logic                init_irdy_n,
  output logic                     it_stop_n,
  output logic                     it_devsel_n,
  output logic                     it_trdy_n,
  output logic                     it_oe,
  // Local target termination causes
  input  wire logic                tgt_req,
  input  wire logic                tgt_no_resource,
  input  wire logic                tgt_delayed_accepted,
  input  wire logic                tgt_no_match,
  input  wire logic                tgt_lock_foreign,
  input  wire logic                tgt_buffer_full,
  input  wire logic                tgt_data_now,
  input  wire logic                init_in_progress,
  input  wire logic                init_disconnected,
  // Abort answers toward the initiator
  output logic      [63:0]         read_data,
  output logic                     read_ones_valid,
  output logic                     drop_write_data,
  // System error, open drain
  output logic                     primary_system_error_n,
  output logic                     primary_system_error_oe,
  // Lock handling
  input  wire logic                lock_release,
  input  wire logic                queues_empty,
  output logic                     sec_lock_n,
  output logic                     sec_lock_oe,
  output logic                     force_unlock,
  output logic                     fwd_as_unlocked
);
  import pci_term_pkg::*;

  typedef struct packed {
    logic [4:0]  sync1;
    logic [4:0]  sync2;
    top_state_t  st;
    logic        tside;
    logic        posted;
    logic        is_read;
    tkind_t      ans;
    logic [3:0]  pstat;
    logic [3:0]  sstat;
    logic        serr;
    logic        lock_hold;
    logic        fwd_unl;
    logic        unlock;
    logic        ones_valid;
    logic        drop_data;
    logic [63:0] rdata;
  } top_regs_t;

  top_regs_t  q, d;
  logic [3:0] pset;
  logic [3:0] sset;
  logic       abort_sec;

  term_if ifc ();

  master_term u_mst (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .ifc     (ifc.mst)
  );

  target_term u_tgt (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .ifc     (ifc.tgt)
  );

  // Pins reach the logic only through the second stage
  assign ifc.mst_start    = (q.st == ST_IDLE) && mst_req;
  assign ifc.mst_mwi      = mst_mwi;
  assign ifc.mst_special  = mst_special;
  assign ifc.tb_devsel_n  = q.sync2[SY_DEVSEL];
  assign ifc.tb_stop_n    = q.sync2[SY_STOP];
  assign ifc.gnt_lost     = q.sync2[SY_GNT];
  assign ifc.init_done    = q.sync2[SY_FRAME] && q.sync2[SY_IRDY];
  assign ifc.init_frame_n = q.sync2[SY_FRAME];
  assign ifc.lat_expired  = lat_expired;
  assign ifc.cl_done      = cacheline_done;
  assign ifc.tgt_kind     = q.ans;

  always_comb
  begin
    d = q;
    pset = 4'h0;
    sset = 4'h0;
    abort_sec = 1'b0;
    d.sync1 = {tb_devsel_n, tb_stop_n, tb_gnt_n, init_frame_n, init_irdy_n};
    d.sync2 = q.sync1;
    d.ans = T_NONE;
    d.serr = 1'b0;
    d.unlock = 1'b0;
    d.ones_valid = 1'b0;
    d.drop_data = 1'b0;
    case (q.st)
      ST_IDLE:
        if (mst_req)
        begin
          d.st = ST_FWD;
          d.tside = mst_side;
          d.posted = mst_posted;
          d.is_read = mst_read;
          // Lost lock: queued locked requests go out unlocked
          if (mst_side && mst_locked && !q.fwd_unl)
            d.lock_hold = 1'b1;
        end
      ST_FWD:
        if (ifc.mst_done)
        begin
          d.st = ST_IDLE;
          case (ifc.mst_res)
            R_MABORT:
            begin
              if (q.tside)
                sset[ST_MA] = 1'b1;
              else
                pset[ST_MA] = 1'b1;
              if (!abort_reporting_select)
              begin
                d.ans = T_NORMAL;
                if (q.is_read)
                begin
                  d.ones_valid = 1'b1;
                  d.rdata = init_bus64 ? ALL_ONES
                                       : {32'h0000_0000, ALL_ONES[31:0]};
                end
                else
                  d.drop_data = 1'b1;
              end
              else if (!q.posted)
                d.ans = T_MABORT;
              else
              begin
                d.serr = serr_enable;
                pset[ST_SES] = 1'b1;
                d.ans = tgt_data_now ? T_DISC_WITH : T_DISC_AFTER;
              end
              abort_sec = q.tside;
            end
            R_TABORT:
            begin
              if (q.tside)
                sset[ST_TAR] = 1'b1;
              else
                pset[ST_TAR] = 1'b1;
              // Reflect only while the initiator is still connected
              if ((!q.posted && !init_disconnected) ||
                  (q.posted && init_in_progress))
              begin
                d.ans = T_TABORT;
                if (q.tside)
                  pset[ST_TAS] = 1'b1;
                else
                  sset[ST_TAS] = 1'b1;
              end
              else if (q.posted)
                d.serr = serr_enable;
              abort_sec = q.tside;
            end
            default: ;
          endcase
        end
      default: d.st = ST_IDLE;
    endcase

    // Abort answers take the initiating side before local causes
    if (d.ans == T_NONE && tgt_req)
    begin
      if (tgt_no_resource || tgt_delayed_accepted ||
          tgt_no_match || tgt_lock_foreign)
        d.ans = T_RETRY;
      else if (tgt_buffer_full)
        d.ans = tgt_data_now ? T_DISC_WITH : T_DISC_AFTER;
    end

    if (lock_release)
      d.lock_hold = 1'b0;
    if (abort_sec)
    begin
      d.lock_hold = 1'b0;
      d.unlock = 1'b1;
    end
    // Set wins over the drain of the queues
    d.fwd_unl = abort_sec || (q.fwd_unl && !queues_empty);

    // Only primary status carries the system error flag
    sset[ST_SES] = 1'b0;
    d.pstat = status_upd(q.pstat, pset, primary_status_clear);
    d.sstat = status_upd(q.sstat, sset, secondary_status_clear);
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
      q <= '{sync1: SYNC_RST, sync2: SYNC_RST, st: ST_IDLE, tside: 1'b0,
             posted: 1'b0, is_read: 1'b0, ans: T_NONE, pstat: STATUS_RST,
             sstat: STATUS_RST, serr: 1'b0, lock_hold: 1'b0,
             fwd_unl: 1'b0, unlock: 1'b0, ones_valid: 1'b0,
             drop_data: 1'b0, rdata: DATA_RST};
    else
      q <= d;
  end

  assign primary_status_reg      = q.pstat;
  assign secondary_status_reg    = q.sstat;
  assign mst_busy                = (q.st == ST_FWD);
  assign tb_frame_drop           = ifc.mst_frame_drop;
  assign tb_hold_bus             = ifc.mst_hold;
  assign it_stop_n               = ifc.tgt_stop_n;
  assign it_devsel_n             = ifc.tgt_devsel_n;
  assign it_trdy_n               = ifc.tgt_trdy_n;
  assign it_oe                   = ifc.tgt_oe;
  assign read_data               = q.rdata;
  assign read_ones_valid         = q.ones_valid;
  assign drop_write_data         = q.drop_data;
  assign primary_system_error_n  = 1'b0;
  assign primary_system_error_oe = q.serr;
  assign sec_lock_n              = 1'b0;
  assign sec_lock_oe             = q.lock_hold;
  assign force_unlock            = q.unlock;
  assign fwd_as_unlocked         = q.fwd_unl;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  ma_flag_a: assert property (
    q.st == ST_FWD && ifc.mst_done && ifc.mst_res == R_MABORT
    |=> (q.tside ? secondary_status_reg[ST_MA] : primary_status_reg[ST_MA]))
    else $error("master-abort flag not set on target side");
  lock_drop_a: assert property (
    q.st == ST_FWD && ifc.mst_done && ifc.mst_res != R_OK && q.tside
    |=> !sec_lock_oe && force_unlock && fwd_as_unlocked)
    else $error("secondary abort kept lock");
  unlock_fwd_a: assert property (
    fwd_as_unlocked && !queues_empty && !mst_req |=> fwd_as_unlocked)
    else $error("unlocked forwarding ended before queues drained");
  ones_read_a: assert property (
    q.st == ST_FWD && ifc.mst_done && ifc.mst_res == R_MABORT &&
    !abort_reporting_select && q.is_read && init_bus64
    |=> read_ones_valid && read_data == ALL_ONES ##1 !it_trdy_n)
    else $error("all-ones read answer missing");
  drop_write_a: assert property (
    q.st == ST_FWD && ifc.mst_done && ifc.mst_res == R_MABORT &&
    !abort_reporting_select && !q.is_read
    |=> drop_write_data ##1 !it_trdy_n && it_stop_n)
    else $error("aborted write not completed normally");
  ma_reflect_a: assert property (
    q.st == ST_FWD && ifc.mst_done && ifc.mst_res == R_MABORT &&
    abort_reporting_select && !q.posted
    |=> q.ans == T_MABORT ##1 !it_oe)
    else $error("delayed request abort not reflected");
  serr_post_a: assert property (
    q.st == ST_FWD && ifc.mst_done && ifc.mst_res == R_MABORT &&
    abort_reporting_select && q.posted && serr_enable
    |=> primary_system_error_oe && primary_status_reg[ST_SES]
        ##1 !primary_system_error_oe && !it_stop_n && !it_devsel_n)
    else $error("posted write abort missing system error");
  ta_reflect_a: assert property (
    q.st == ST_FWD && ifc.mst_done && ifc.mst_res == R_TABORT &&
    !q.posted && !init_disconnected
    |=> ##1 !it_stop_n && it_devsel_n)
    else $error("target-abort not reflected");
  retry_ans_a: assert property (
    tgt_req && tgt_no_resource && !(q.st == ST_FWD && ifc.mst_done)
    |=> ##1 !it_stop_n && !it_devsel_n && it_trdy_n)
    else $error("retry not signalled");
  flag_sticky_a: assert property (
    primary_status_reg[ST_MA] && !primary_status_clear[ST_MA]
    |=> primary_status_reg[ST_MA])
    else $error("status flag lost without clear");
  ta_no_reflect_a: assert property (
    q.st == ST_FWD && ifc.mst_done && ifc.mst_res == R_TABORT &&
    !q.posted && init_disconnected
    |=> q.ans != T_TABORT)
    else $error("target-abort reflected after disconnect");
  ta_posted_a: assert property (
    q.st == ST_FWD && ifc.mst_done && ifc.mst_res == R_TABORT &&
    q.posted && !init_in_progress
    |=> primary_system_error_oe == $past(serr_enable) && q.ans != T_TABORT)
    else $error("completed posted write abort not reported");
endmodule
`default_nettype wire

// file: tb/pci_target_model.sv
`timescale 1ns/100ps
`default_nettype none
module pci_target_model (
  // Clock and mode
  input  wire logic       clk_sys,
  input  wire logic       busy,
  input  wire logic [1:0] mode,
  // Target bus pins
  output logic            devsel_n = 1'b1,
  output logic            stop_n = 1'b1,
  output logic            gnt_n
);
  int cnt = 0;
  // Mode 3 claims for good and takes the grant away
  assign gnt_n = (mode == 2'h3);
  always @(negedge clk_sys)
  begin
    cnt = (busy === 1'b1) ? cnt + 1 : 0;
    // Claims within the decode window
    devsel_n <= !(mode != 2'h0 && cnt > 1 && (mode[0] || cnt < 4));
    // Abort withdraws DEVSEL on the same edge that asserts STOP
    stop_n <= !(mode == 2'h2 && cnt > 3);
  end
endmodule
`default_nettype wire

// file: tb/tb_pci_termination.sv
`timescale 1ns/100ps
`default_nettype none
module tb_pci_termination;
  import pci_term_pkg::*;
  logic clk_sys = 1'b0;
  logic rstn, abort_reporting_select, serr_enable, init_bus64, mst_req;
  logic mst_side, mst_read, mst_posted, mst_mwi, mst_special, mst_locked;
  logic mst_busy, lat_expired, cacheline_done, tb_devsel_n, tb_stop_n;
  logic tb_gnt_n, tb_frame_drop, tb_hold_bus, init_frame_n, init_irdy_n;
  logic it_stop_n, it_devsel_n, it_trdy_n, it_oe, tgt_req, tgt_no_resource;
  logic tgt_delayed_accepted, tgt_no_match, tgt_lock_foreign, tgt_data_now;
  logic tgt_buffer_full, init_in_progress, init_disconnected, read_ones_valid;
  logic drop_write_data, primary_system_error_n, primary_system_error_oe;
  logic lock_release, queues_empty, sec_lock_n, sec_lock_oe, force_unlock;
  logic fwd_as_unlocked, sd, rd, sp, s_ones, s_drop, s_serr, s_fdrop;
  logic [3:0] primary_status_clear, secondary_status_clear;
  logic [3:0] primary_status_reg, secondary_status_reg;
  logic [63:0] read_data, ones_data;
  logic [1:0] pmode;
  int error_cnt = 0;
  int compares = 0;
  pci_termination u_pci_termination (.clk_sys, .rstn, .abort_reporting_select,
    .serr_enable, .init_bus64, .primary_status_clear, .secondary_status_clear,
    .primary_status_reg, .secondary_status_reg, .mst_req, .mst_side, .mst_read,
    .mst_posted, .mst_mwi, .mst_special, .mst_locked, .mst_busy, .lat_expired,
    .cacheline_done, .tb_devsel_n, .tb_stop_n, .tb_gnt_n, .tb_frame_drop,
    .tb_hold_bus, .init_frame_n, .init_irdy_n, .it_stop_n, .it_devsel_n,
    .it_trdy_n, .it_oe, .tgt_req, .tgt_no_resource, .tgt_delayed_accepted,
    .tgt_no_match, .tgt_lock_foreign, .tgt_buffer_full, .tgt_data_now,
    .init_in_progress, .init_disconnected, .read_data, .read_ones_valid,
    .drop_write_data, .primary_system_error_n, .primary_system_error_oe,
    .lock_release, .queues_empty, .sec_lock_n, .sec_lock_oe, .force_unlock,
    .fwd_as_unlocked);
  pci_target_model u_pci_target_model (.clk_sys, .busy(mst_busy), .mode(pmode),
    .devsel_n(tb_devsel_n), .stop_n(tb_stop_n), .gnt_n(tb_gnt_n));
  always #2 clk_sys = ~clk_sys;
  // One-cycle pulses are caught here so checks can look later
  always @(posedge clk_sys)
  begin
    if (read_ones_valid === 1'b1) {s_ones, ones_data} <= {1'b1, read_data};
    if (drop_write_data === 1'b1) s_drop <= 1'b1;
    if (primary_system_error_oe === 1'b1) s_serr <= 1'b1;
    if (tb_frame_drop === 1'b1) s_fdrop <= 1'b1;
  end
  function automatic logic fl(input logic s, input int b);
    return s ? secondary_status_reg[b] : primary_status_reg[b];
  endfunction
  task automatic chk(input logic ok, input string m);
    compares++;
    if (ok !== 1'b1)
    begin
      error_cnt++;
      $display("BAD %0t %s", $time, m);
    end
  endtask
  task automatic stop_test;
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic fwd(input logic po);
    {s_ones, s_drop, s_serr, s_fdrop} = 4'h0;
    {mst_side, mst_read, mst_posted, mst_special} = {sd, rd, po, sp};
    {mst_locked, queues_empty, lock_release} = 3'($urandom);
    mst_req = 1'b1;
    @(negedge clk_sys) mst_req = 1'b0;
    for (int i = 0; i < 60 && mst_busy !== 1'b0; i++) @(negedge clk_sys);
    repeat (5) @(negedge clk_sys);
  endtask
  task automatic clr;
    {primary_status_clear, secondary_status_clear} = 8'hff;
    @(negedge clk_sys) {primary_status_clear, secondary_status_clear} = 8'h00;
    @(negedge clk_sys);
    chk({primary_status_reg, secondary_status_reg} === 8'h00, "clear");
  endtask
  initial
  begin
    {rstn, abort_reporting_select, serr_enable, init_bus64, mst_req} = 5'h0;
    {mst_side, mst_read, mst_posted, mst_mwi, mst_special, mst_locked} = 6'h0;
    {lat_expired, cacheline_done, tgt_req, tgt_no_resource, sd, rd, sp} = 7'h0;
    {tgt_delayed_accepted, tgt_no_match, tgt_lock_foreign, tgt_data_now} = 4'h0;
    {tgt_buffer_full, init_in_progress, init_disconnected, lock_release} = 4'h0;
    {init_frame_n, init_irdy_n, queues_empty, pmode} = 5'h1c;
    {primary_status_clear, secondary_status_clear} = 8'h00;
    void'($urandom(70));
    repeat (4) @(negedge clk_sys);
    rstn = 1'b1;
    chk({primary_status_reg, secondary_status_reg, it_oe} === 9'h0, "rst");
    for (int n = 0; n < 10; n++)
    begin
      {init_bus64, sd, rd, sp} = 4'($urandom);
      fwd(1'b0);
      chk(fl(sd, ST_MA) === !sp, "ma flag");
      if (!sp && rd)
        chk(s_ones === 1'b1 && ones_data === (init_bus64 ? ALL_ONES : 64'hffff_ffff), "ones");
      if (!sp && !rd)
        chk(s_drop === 1'b1, "drop");
      clr();
    end
    {abort_reporting_select, serr_enable, sp, rd} = 4'hc;
    fwd(1'b1);
    chk(s_serr && primary_status_reg[ST_SES] && fl(sd, ST_MA), "serr");
    clr();
    rd = 1'b1;
    fwd(1'b0);
    chk(s_ones === 1'b0 && fl(sd, ST_MA) === 1'b1, "reflect");
    clr();
    // Initiator stays on the bus so the abort is still reflected
    {init_frame_n, init_irdy_n, pmode} = 4'h2;
    fwd(1'b0);
    chk(fl(sd, ST_TAR) === 1'b1 && fl(!sd, ST_TAS) === 1'b1, "tabort");
    chk(it_stop_n === 1'b0 && it_devsel_n === 1'b1, "ta pins");
    {init_frame_n, init_irdy_n} = 2'h3;
    clr();
    pmode = 2'h1;
    fwd(1'b0);
    chk(s_fdrop === 1'b1 && primary_status_reg === 4'h0, "normal");
    {init_frame_n, init_irdy_n, pmode, mst_mwi, lat_expired} = 6'h0f;
    fwd(1'b1);
    chk(tb_hold_bus === 1'b1 && s_fdrop === 1'b0, "mwi hold");
    cacheline_done = 1'b1;
    repeat (4) @(negedge clk_sys);
    chk(s_fdrop === 1'b1 && mst_busy === 1'b0, "mwi line");
    {mst_mwi, cacheline_done} = 2'h0;
    fwd(1'b0);
    chk(s_fdrop === 1'b1 && tb_hold_bus === 1'b0, "timeout");
    for (int k = 0; k < 6; k++)
    begin
      {init_frame_n, init_irdy_n} = 2'h0;
      repeat (3) @(negedge clk_sys);
      {tgt_buffer_full, tgt_lock_foreign, tgt_no_match, tgt_delayed_accepted,
        tgt_no_resource} = (k < 5) ? 5'h1 << k : 5'h10;
      tgt_data_now = (k == 5);
      tgt_req = 1'b1;
      @(negedge clk_sys) tgt_req = 1'b0;
      repeat (3) @(negedge clk_sys);
      chk({it_stop_n, it_devsel_n, it_trdy_n, it_oe} === 4'h3, "retry");
      {init_frame_n, init_irdy_n} = 2'h3;
      repeat (6) @(negedge clk_sys);
      chk(it_oe === 1'b0 && it_stop_n === 1'b1, "release");
    end
    stop_test();
  end
  initial
  begin
    #200000;
    error_cnt++;
    stop_test();
  end
endmodule
`default_nettype wire
